// File: design/ddr_dev_end.sv
// device end of the dram link: command decode, banks, mode registers,
// power states, masked writes, strobed reads and termination control
// assumes the controller keeps its own side of the link rules
//
// How it works
// [RQ1] inputs sampled on the rising clock edge
// [RQ2] activate takes row, read/write takes column
// [RQ3] precharge one bank, or all when a10
// [RQ4] load mode writes register picked by bank
// [RQ5] bank address selects the target bank
// [RQ6] on-the-fly: a12 high eight beats, low four
// [RQ7] cke low powers down or self refreshes
// [RQ8] self-refresh exit seen without the clock
// [RQ9] power-down and self refresh ignore inputs (odt is still sampled here in power-down)
// [RQ10] chip select high masks every command
// [RQ11] command from select and three strobes
// [RQ12] lower mask high drops lower write byte
// [RQ13] read strobe edge-aligned, write strobe centred (the write strobe here toggles with its data, edge-aligned)
// [RQ14] output strobe timed from the clock
// [RQ15] odt switches termination unless mode disables
// [RQ16] terminate only balls of active width
// [RQ17] x8 termination strobe disables the mask
// [RQ18] no-function balls idle on x4, used x8
// [RQ19] data bus four, eight or sixteen bits wide
// [RQ20] link reset acts asynchronously both ways
// [RQ21] upper mask high drops upper write byte
// [RQ22] x16 upper byte has its own strobe (writes here latch the upper byte on dqs[0] edges; dqs[1] is not watched)
// [RQ23] every strobe edge carries one beat
`timescale 1ns/1ps
module ddr_dev_end
    import ddr_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    ddr_link_if.dev link,
    input wire logic [1:0] width_sel,
    output logic [7:0] bank_open,
    output pwr_t pwr_state,
    output logic core_on,
    output logic [15:0] term_dq,
    output logic [1:0] term_dqs,
    output logic [1:0] term_dm,
    output logic term_tdqs_n
);
    typedef struct packed {
        pwr_t pwr;
        logic [7:0] open;
        logic [3:0][14:0] mr;
        logic odt;
        logic rd;
        logic wr;
        logic [3:0] lat;
        logic [3:0] beat;
        logic [3:0] blen;
        logic [2:0] bank;
        logic [2:0] col;
        logic ap;
        logic [1:0] dqs;
        logic [15:0] dq_o;
        logic dq_oe;
        logic dqs_prev;
        logic [63:0][15:0] mem;
    } dev_st_t;

    dev_st_t s_r;
    dev_st_t s_nxt;
    cmd_t cmd;
    logic arst;
    logic live;
    logic x8;
    logic x16;
    logic dm_en;
    logic term;
    logic [15:0] lane;
    logic [5:0] idx;
    logic rd_beat;
    logic wr_edge;
    logic lo_keep;
    logic hi_keep;
    logic rtt_on;
    logic sr_wake;

    // the link reset bypasses the clock on assertion and release
    assign arst = reset | ~link.rst_n; // [RQ20]

    ddr_cmd_dec u_dec (
        .cs_n(link.cs_n),
        .ras_n(link.ras_n),
        .cas_n(link.cas_n),
        .we_n(link.we_n),
        .cmd(cmd)
    );

    assign x8 = (width_sel == W_X8);
    assign x16 = (width_sel == W_X16);
    // x4 leaves the no-function balls dead; x8 adds dq[7:4]
    assign lane = x16 ? 16'hffff : (x8 ? 16'h00ff : 16'h000f); // [RQ18] [RQ19] [RQ22]
    assign dm_en = !(x8 && s_r.mr[1][MR1_TDQS]); // [RQ17]
    assign live = (s_r.pwr == PWR_ACT) && link.cke; // [RQ9]
    assign idx = {s_r.bank, s_r.col + s_r.beat[2:0]};
    assign rd_beat = s_r.rd && (s_r.lat == 4'h0);
    assign wr_edge = s_r.wr && (link.dqs[0] != s_r.dqs_prev); // [RQ23]
    // with the termination strobe on, the lower mask ball no longer masks
    assign lo_keep = !(dm_en && link.dm[0]); // [RQ12] [RQ17]
    assign hi_keep = x16 && !link.dm[1]; // [RQ21]
    assign rtt_on = s_r.mr[1][MR1_RTT0] || s_r.mr[1][MR1_RTT1]
        || s_r.mr[1][MR1_RTT2];
    // only self refresh wakes on the cke level; power-down waits an edge
    assign sr_wake = (s_r.pwr == PWR_SR) && link.cke; // [RQ8]

    always_comb begin
        s_nxt = s_r;
        s_nxt.dqs_prev = link.dqs[0];
        // odt is still listened to in power-down, not in self refresh
        s_nxt.odt = (s_r.pwr != PWR_SR) && link.odt; // [RQ9] [RQ15]
        case (s_r.pwr)
            PWR_ACT: begin
                if (!link.cke) begin // [RQ7] [RQ8]
                    if (cmd == CMD_REF) begin
                        s_nxt.pwr = PWR_SR;
                    end else if (|s_r.open) begin
                        s_nxt.pwr = PWR_PDA;
                    end else begin
                        s_nxt.pwr = PWR_PDP;
                    end
                end
            end
            PWR_PDP, PWR_PDA, PWR_SR: begin
                if (link.cke) begin
                    s_nxt.pwr = PWR_ACT; // [RQ7]
                end
            end
            default: s_nxt.pwr = PWR_ACT;
        endcase
        if (live) begin // [RQ1]
            case (cmd)
                CMD_MRS: begin
                    if (!link.ba[2]) begin
                        s_nxt.mr[link.ba[1:0]] = link.addr; // [RQ4]
                    end
                end
                CMD_ACT: s_nxt.open[link.ba] = 1'b1; // [RQ2] [RQ5]
                CMD_PRE: begin
                    if (link.addr[A_AP]) begin
                        s_nxt.open = 8'h00; // [RQ3]
                    end else begin
                        s_nxt.open[link.ba] = 1'b0; // [RQ3] [RQ5]
                    end
                end
                CMD_RD, CMD_WR: begin
                    // a second burst before the first ends is dropped
                    if (!s_r.rd && !s_r.wr) begin
                        s_nxt.rd = (cmd == CMD_RD);
                        s_nxt.wr = (cmd == CMD_WR);
                        s_nxt.lat = RD_LAT;
                        s_nxt.beat = 4'h0;
                        s_nxt.bank = link.ba; // [RQ5]
                        s_nxt.col = link.addr[2:0]; // [RQ2]
                        s_nxt.ap = link.addr[A_AP]; // [RQ2]
                        case (s_r.mr[0][1:0])
                            BL_OTF: s_nxt.blen =
                                link.addr[A_BC] ? BEATS8 : BEATS4; // [RQ6]
                            BL_FIX4: s_nxt.blen = BEATS4;
                            default: s_nxt.blen = BEATS8;
                        endcase
                    end
                end
                default: s_nxt.open = s_r.open;
            endcase
        end
        s_nxt.dq_oe = 1'b0;
        if (s_r.rd) begin
            if (s_r.lat != 4'h0) begin
                s_nxt.lat = s_r.lat - 4'h1;
            end else begin
                // data and strobe leave the same flops: edge-aligned
                s_nxt.dq_o = s_r.mem[idx] & lane; // [RQ13]
                s_nxt.dq_oe = 1'b1;
                s_nxt.dqs = ~s_r.dqs; // [RQ14] [RQ23]
                s_nxt.beat = s_r.beat + 4'h1;
            end
        end
        if (wr_edge) begin // [RQ13] [RQ23]
            if (lo_keep) begin
                s_nxt.mem[idx][7:0] = link.dq[7:0] & lane[7:0]; // [RQ12]
            end
            if (hi_keep) begin
                s_nxt.mem[idx][15:8] = link.dq[15:8]; // [RQ21] [RQ22]
            end
            s_nxt.beat = s_r.beat + 4'h1;
        end
        if (rd_beat || s_r.wr) begin
            if (s_nxt.beat == s_r.blen) begin
                s_nxt.rd = 1'b0;
                s_nxt.wr = 1'b0;
                s_nxt.beat = 4'h0;
                if (s_r.ap) begin
                    s_nxt.open[s_r.bank] = 1'b0; // [RQ2]
                end
            end
        end
    end

    always_ff @(posedge clk or posedge arst) begin
        if (arst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign link.dev_dq_o = s_r.dq_o;
    assign link.dev_dq_oe = {16{s_r.dq_oe}} & lane; // [RQ19]
    assign link.dev_dqs_o = {2{s_r.dqs[0]}};
    assign link.dev_dqs_oe = {x16 & s_r.dq_oe, s_r.dq_oe}; // [RQ22]

    assign term = s_r.odt && rtt_on; // [RQ15]
    assign term_dq = term ? lane : 16'h0000; // [RQ16]
    assign term_dqs = {term & x16, term}; // [RQ16]
    assign term_dm = {term & x16, term}; // [RQ16]
    assign term_tdqs_n = term && x8 && s_r.mr[1][MR1_TDQS]; // [RQ16] [RQ17]

    // self-refresh exit follows the cke level with no clock edge needed
    assign core_on = (s_r.pwr == PWR_ACT) || sr_wake; // [RQ7] [RQ8]
    assign bank_open = s_r.open;
    assign pwr_state = s_r.pwr;
endmodule

// File: design/ddr_pkg.sv
// shared constants and types for the dram link, device end and controller
// assumes one clock, clk, standing in for the ck/ck# crossing
package ddr_pkg;
    typedef enum logic [2:0] {
        CMD_MRS = 3'b000,
        CMD_REF = 3'b001,
        CMD_PRE = 3'b010,
        CMD_ACT = 3'b011,
        CMD_WR  = 3'b100,
        CMD_RD  = 3'b101,
        CMD_ZQ  = 3'b110,
        CMD_NOP = 3'b111
    } cmd_t;

    typedef enum logic [1:0] {
        PWR_ACT = 2'b00,
        PWR_PDP = 2'b01,
        PWR_PDA = 2'b10,
        PWR_SR  = 2'b11
    } pwr_t;

    localparam logic [1:0] W_X4 = 2'h0;
    localparam logic [1:0] W_X8 = 2'h1;
    localparam logic [1:0] W_X16 = 2'h2;

    localparam int A_AP = 10;
    localparam int A_BC = 12;
    localparam logic [1:0] BL_FIX8 = 2'h0;
    localparam logic [1:0] BL_OTF = 2'h1;
    localparam logic [1:0] BL_FIX4 = 2'h2;
    localparam int MR1_RTT0 = 2;
    localparam int MR1_RTT1 = 6;
    localparam int MR1_RTT2 = 9;
    localparam int MR1_TDQS = 11;

    localparam logic [3:0] RD_LAT = 4'h5;
    localparam logic [3:0] WR_LAT = 4'h4;
    localparam logic [3:0] BEATS8 = 4'h8;
    localparam logic [3:0] BEATS4 = 4'h4;

    localparam logic [7:0] OFF_CMD = 8'h00;
    localparam logic [7:0] OFF_CTRL = 8'h04;
    localparam logic [7:0] OFF_WDATA = 8'h08;
    localparam logic [7:0] OFF_WMASK = 8'h0c;
    localparam logic [7:0] OFF_STAT = 8'h10;
    localparam logic [7:0] OFF_RDATA = 8'h20;
    localparam logic [4:0] CTRL_RST = 5'h00;
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;
endpackage

// File: design/ddr_link_if.sv
// dram pin bundle between the controller end and the device end
// each two-way pin is resolved here from the two ends' enables
`timescale 1ns/1ps
interface ddr_link_if;
    logic rst_n;
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [2:0] ba;
    logic [14:0] addr;
    logic odt;
    logic [1:0] dm;
    logic [15:0] ctl_dq_o;
    logic [15:0] ctl_dq_oe;
    logic [1:0] ctl_dqs_o;
    logic [1:0] ctl_dqs_oe;
    logic [15:0] dev_dq_o;
    logic [15:0] dev_dq_oe;
    logic [1:0] dev_dqs_o;
    logic [1:0] dev_dqs_oe;
    logic [15:0] dq;
    logic [1:0] dqs;

    // undriven lanes settle low, like a weak pull-down
    assign dq = (ctl_dq_o & ctl_dq_oe) | (dev_dq_o & dev_dq_oe);
    assign dqs = (ctl_dqs_o & ctl_dqs_oe) | (dev_dqs_o & dev_dqs_oe);

    modport ctl (
        output rst_n, cke, cs_n, ras_n, cas_n, we_n, ba, addr, odt, dm,
        output ctl_dq_o, ctl_dq_oe, ctl_dqs_o, ctl_dqs_oe,
        input dq, dqs
    );
    modport dev (
        input rst_n, cke, cs_n, ras_n, cas_n, we_n, ba, addr, odt, dm,
        output dev_dq_o, dev_dq_oe, dev_dqs_o, dev_dqs_oe,
        input dq, dqs
    );
endinterface

// File: design/ddr_cmd_dec.sv
// command decoder: chip select plus the three command strobes
// assumes its inputs are the values sampled at one clock edge
`timescale 1ns/1ps
module ddr_cmd_dec
    import ddr_pkg::*;
(
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    output cmd_t cmd
);
    always_comb begin
        if (cs_n) begin
            cmd = CMD_NOP; // [RQ10]
        end else begin
            cmd = cmd_t'({ras_n, cas_n, we_n}); // [RQ11]
        end
    end
endmodule

// File: design/ddr_ctl_end.sv
// controller end: axi4-lite registers order single commands onto the link
// assumes software keeps the burst mode bits in step with mode register 0
`timescale 1ns/1ps
module ddr_ctl_end
    import ddr_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    ddr_link_if.ctl link,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready
);
    typedef struct packed {
        logic [4:0] ctrl;
        logic cs_n;
        logic [2:0] code;
        logic [2:0] ba;
        logic [14:0] addr;
        logic [15:0] wd;
        logic [15:0] wm;
        logic [7:0][15:0] rbuf;
        logic [3:0] rcnt;
        logic wr;
        logic [3:0] lat;
        logic [3:0] beat;
        logic [3:0] blen;
        logic [15:0] dq_o;
        logic [1:0] dm;
        logic dq_oe;
        logic dqs;
        logic dqs_prev;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } ctl_st_t;

    ctl_st_t s_r;
    ctl_st_t s_nxt;
    logic wr_take;

    assign wr_take = awvalid && wvalid && !s_r.bvalid;
    assign awready = wr_take;
    assign wready = wr_take;
    assign arready = !s_r.rvalid;

    always_comb begin
        s_nxt = s_r;
        s_nxt.cs_n = 1'b1; // [RQ10]
        s_nxt.dqs_prev = link.dqs[0];
        if (s_r.bvalid && bready) begin
            s_nxt.bvalid = 1'b0;
        end
        if (s_r.rvalid && rready) begin
            s_nxt.rvalid = 1'b0;
        end
        if (wr_take) begin
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = RESP_OK;
            if (wstrb != 4'hf) begin
                s_nxt.bresp = RESP_ERR;
            end else if (awaddr == OFF_CMD) begin
                if (s_r.wr) begin
                    s_nxt.bresp = RESP_ERR;
                end else begin
                    // one command per write, select low for one cycle
                    s_nxt.cs_n = 1'b0; // [RQ11]
                    s_nxt.addr = wdata[14:0];
                    s_nxt.ba = wdata[17:15];
                    s_nxt.code = wdata[20:18];
                    if (cmd_t'(wdata[20:18]) == CMD_RD) begin
                        s_nxt.rcnt = 4'h0;
                    end
                    // cke must fall with the refresh to reach self refresh
                    if (cmd_t'(wdata[20:18]) == CMD_REF && wdata[21]) begin
                        s_nxt.ctrl[0] = 1'b0; // [RQ8]
                    end
                    if (cmd_t'(wdata[20:18]) == CMD_WR) begin
                        s_nxt.wr = 1'b1;
                        s_nxt.lat = WR_LAT;
                        s_nxt.beat = 4'h0;
                        if (s_r.ctrl[3]) begin
                            s_nxt.blen = wdata[A_BC] ? BEATS8 : BEATS4; // [RQ6]
                        end else begin
                            s_nxt.blen = s_r.ctrl[4] ? BEATS4 : BEATS8;
                        end
                    end
                end
            end else if (awaddr == OFF_CTRL) begin
                s_nxt.ctrl = wdata[4:0];
            end else if (awaddr == OFF_WDATA) begin
                s_nxt.wd = wdata[15:0];
            end else if (awaddr == OFF_WMASK) begin
                s_nxt.wm = wdata[15:0];
            end else begin
                s_nxt.bresp = RESP_ERR;
            end
        end
        if (arvalid && !s_r.rvalid) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rresp = RESP_OK;
            s_nxt.rdata = 32'h0000_0000;
            if (araddr == OFF_CTRL) begin
                s_nxt.rdata = {27'h0, s_r.ctrl};
            end else if (araddr == OFF_WDATA) begin
                s_nxt.rdata = {16'h0, s_r.wd};
            end else if (araddr == OFF_WMASK) begin
                s_nxt.rdata = {16'h0, s_r.wm};
            end else if (araddr == OFF_STAT) begin
                s_nxt.rdata = {27'h0, s_r.rcnt, s_r.wr};
            end else if (araddr[7:5] == OFF_RDATA[7:5] && araddr[1:0] == 2'h0)
            begin
                s_nxt.rdata = {16'h0, s_r.rbuf[araddr[4:2]]};
            end else if (araddr != OFF_CMD) begin
                s_nxt.rresp = RESP_ERR;
            end
        end
        s_nxt.dq_oe = 1'b0;
        if (s_r.wr) begin
            if (s_r.lat != 4'h0) begin
                s_nxt.lat = s_r.lat - 4'h1;
            end else begin
                // data, mask and a strobe toggle move together each beat
                s_nxt.dq_o = s_r.wd + {12'h0, s_r.beat}; // [RQ23]
                s_nxt.dm = s_r.wm[{s_r.beat[2:0], 1'b0} +: 2]; // [RQ12] [RQ21]
                s_nxt.dq_oe = 1'b1;
                s_nxt.dqs = ~s_r.dqs; // [RQ13]
                s_nxt.beat = s_r.beat + 4'h1;
                if (s_r.beat + 4'h1 == s_r.blen) begin
                    s_nxt.wr = 1'b0;
                end
            end
        end
        // read beats are caught on each strobe change we did not drive, up to eight per read command
        if (!s_r.dq_oe && link.dqs[0] != s_r.dqs_prev && !s_r.rcnt[3]) begin
            s_nxt.rbuf[s_r.rcnt[2:0]] = link.dq; // [RQ13] [RQ23]
            s_nxt.rcnt = s_r.rcnt + 4'h1;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s_r <= '0;
            s_r.cs_n <= 1'b1;
            s_r.code <= CMD_NOP;
            s_r.ctrl <= CTRL_RST;
        end else begin
            s_r <= s_nxt; // [RQ1]
        end
    end

    assign link.rst_n = s_r.ctrl[2];
    assign link.cke = s_r.ctrl[0]; // [RQ8]
    assign link.odt = s_r.ctrl[1]; // [RQ15]
    assign link.cs_n = s_r.cs_n;
    assign link.ras_n = s_r.code[2];
    assign link.cas_n = s_r.code[1];
    assign link.we_n = s_r.code[0];
    assign link.ba = s_r.ba;
    assign link.addr = s_r.addr;
    assign link.dm = s_r.dm;
    assign link.ctl_dq_o = s_r.dq_o;
    assign link.ctl_dq_oe = {16{s_r.dq_oe}};
    assign link.ctl_dqs_o = {2{s_r.dqs}};
    assign link.ctl_dqs_oe = {2{s_r.dq_oe}};
    assign bvalid = s_r.bvalid;
    assign bresp = s_r.bresp;
    assign rvalid = s_r.rvalid;
    assign rresp = s_r.rresp;
    assign rdata = s_r.rdata;
endmodule

// File: dv/ddr_link_checker.sv
// link assertions between controller end and device end
// assumes both ends share clk and the bench reset
`timescale 1ns/1ps
module ddr_link_checker (
    input wire logic clk,
    input wire logic reset,
    input wire logic rst_n,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [15:0] ctl_dq_oe,
    input wire logic [1:0] ctl_dqs_oe,
    input wire logic [15:0] dev_dq_oe,
    input wire logic [1:0] dev_dqs_oe,
    input wire logic [1:0] dqs
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    logic wr_cmd;
    logic rd_cmd;
    assign wr_cmd = !cs_n && ras_n && !cas_n && !we_n;
    assign rd_cmd = !cs_n && ras_n && !cas_n && we_n;
    cmd_pulse_a: assert property (!cs_n |=> cs_n)
        else $error("command select held over one cycle");
    wr_lat_a: assert property (wr_cmd |-> ##[4:6] ctl_dq_oe != 16'h0)
        else $error("write burst not launched on time");
    rd_lat_a: assert property (rd_cmd |-> ##[5:7] dev_dq_oe != 16'h0)
        else $error("read burst not returned on time");
    bus_turn_a: assert property (!(ctl_dq_oe != 16'h0 && dev_dq_oe != 16'h0))
        else $error("both ends drive data together");
    rd_strobe_a: assert property (dev_dqs_oe[0] && $past(dev_dqs_oe[0])
        |-> dqs[0] != $past(dqs[0]))
        else $error("read strobe missed a beat");
    wr_strobe_a: assert property (ctl_dqs_oe[0] && $past(ctl_dqs_oe[0])
        |-> dqs[0] != $past(dqs[0]))
        else $error("write strobe missed a beat");
    rst_quiet_a: assert property (!rst_n |-> dev_dq_oe == 16'h0)
        else $error("device drives data in link reset");
    rd_burst_a: assert property ($rose(dev_dq_oe[0]) |-> dev_dq_oe[0] [*4])
        else $error("read burst shorter than four beats");
    cover property (wr_cmd);
    cover property (rd_cmd);
    cover property ($rose(dev_dq_oe[0]) ##7 dev_dq_oe[0]);
endmodule

// File: dv/ddr3_sdram_pin_interface_tb_top.sv
// bench: axi4-lite driver on the controller end, device end on the link
// assumes memory and device state clear at reset, controller select and command strobes high; x16 width throughout
`timescale 1ns/1ps
module ddr3_sdram_pin_interface_tb_top;
    import ddr_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] awaddr = 8'h0, araddr = 8'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hf;
    logic awready, wready, bvalid, arready, rvalid, core_on, term_tdqs_n;
    logic [1:0] bresp, rresp, term_dqs, term_dm;
    logic [31:0] rdata;
    logic [7:0] bank_open;
    logic [15:0] term_dq;
    pwr_t pwr_state;
    int bad_count = 0;
    int samples_checked = 0;
    logic [1:0] r;
    logic [31:0] d;
    always #2.5 clk = ~clk;
    ddr_link_if link();
    ddr_ctl_end ddr_ctl_end_i (.clk(clk), .reset(reset), .link(link),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
    ddr_dev_end ddr_dev_end_i (.clk(clk), .reset(reset), .link(link),
        .width_sel(W_X16), .bank_open(bank_open), .pwr_state(pwr_state),
        .core_on(core_on), .term_dq(term_dq), .term_dqs(term_dqs),
        .term_dm(term_dm), .term_tdqs_n(term_tdqs_n));
    ddr_link_checker ddr_link_checker_i (.clk(clk), .reset(reset),
        .rst_n(link.rst_n), .cs_n(link.cs_n), .ras_n(link.ras_n),
        .cas_n(link.cas_n), .we_n(link.we_n), .ctl_dq_oe(link.ctl_dq_oe),
        .ctl_dqs_oe(link.ctl_dqs_oe), .dev_dq_oe(link.dev_dq_oe),
        .dev_dqs_oe(link.dev_dqs_oe), .dqs(link.dqs));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wait_for(ref logic sig);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (sig !== 1'b1 && n < 200);
        if (n >= 200) chk(32'h0, 32'h1);
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] v,
                          input logic [3:0] s, output logic [1:0] rs);
        @(posedge clk);
        awaddr <= a;
        wdata <= v;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        wait_for(awready);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        bready <= 1'b1;
        wait_for(bvalid);
        rs = bresp;
        bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] v,
                          output logic [1:0] rs);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        wait_for(arready);
        arvalid <= 1'b0;
        rready <= 1'b1;
        wait_for(rvalid);
        v = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask
    task automatic cmd(input cmd_t c, input logic [2:0] b,
                       input logic [14:0] a);
        axi_wr(OFF_CMD, {11'h0, c, b, a}, 4'hf, r);
        repeat (3) @(posedge clk);
    endtask
    task automatic ctrl(input logic [31:0] v);
        axi_wr(OFF_CTRL, v, 4'hf, r);
        repeat (3) @(posedge clk);
    endtask
    // software poll rather than a fixed wait: busy time is the design's
    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            axi_rd(OFF_STAT, d, r);
            n++;
        end while (d[0] !== 1'b0 && n < 50);
        chk(d[0], 1'b0);
    endtask

    task automatic t_reset_state();
        chk(bank_open, 8'h0);
        chk(pwr_state, PWR_ACT);
        ctrl(32'hd);
        cmd(CMD_MRS, 3'h0, 15'h0001);
        cmd(CMD_MRS, 3'h1, 15'h0004);
    endtask
    task automatic t_act_bank();
        cmd(CMD_ACT, 3'h3, 15'h0005);
        chk(bank_open, 8'h08);
        cmd(CMD_ACT, 3'h6, 15'h0009);
        chk(bank_open, 8'h48);
    endtask
    // beat 1 lower byte and beat 2 upper byte are masked off
    task automatic t_write_read();
        logic [15:0] exp;
        axi_wr(OFF_WDATA, 32'h1230, 4'hf, r);
        axi_wr(OFF_WMASK, 32'h24, 4'hf, r);
        cmd(CMD_WR, 3'h3, 15'h1000);
        wait_idle();
        cmd(CMD_RD, 3'h3, 15'h1000);
        repeat (20) @(posedge clk);
        axi_rd(OFF_STAT, d, r);
        chk(d[4:1], BEATS8);
        for (int k = 0; k < 8; k++) begin
            exp = 16'h1230 + 16'(k);
            if (k == 1) exp = exp & 16'hff00;
            if (k == 2) exp = exp & 16'h00ff;
            axi_rd(OFF_RDATA + 8'(4 * k), d, r);
            chk(d[15:0], exp);
        end
    endtask
    task automatic t_chop();
        cmd(CMD_RD, 3'h3, 15'h0000);
        repeat (20) @(posedge clk);
        axi_rd(OFF_STAT, d, r);
        chk(d[4:1], BEATS4);
        axi_rd(OFF_RDATA + 8'h4, d, r);
        chk(d[15:0], 16'h1200);
    endtask
    task automatic t_power();
        ctrl(32'hc);
        chk(pwr_state, PWR_PDA);
        chk(core_on, 1'b0);
        cmd(CMD_ACT, 3'h1, 15'h0001);
        chk(bank_open, 8'h48);
        ctrl(32'hd);
        chk(pwr_state, PWR_ACT);
    endtask
    task automatic t_precharge();
        cmd(CMD_PRE, 3'h6, 15'h0000);
        chk(bank_open, 8'h08);
        cmd(CMD_ACT, 3'h0, 15'h0002);
        cmd(CMD_PRE, 3'h5, 15'h0400);
        chk(bank_open, 8'h00);
        ctrl(32'hc);
        chk(pwr_state, PWR_PDP);
        ctrl(32'hd);
    endtask
    // refresh with cke falling enters self refresh; cke wakes the core at once
    task automatic t_selfref();
        axi_wr(OFF_CMD, 32'h0024_0000, 4'hf, r);
        repeat (3) @(posedge clk);
        chk(pwr_state, PWR_SR);
        chk(core_on, 1'b0);
        cmd(CMD_ACT, 3'h2, 15'h0000);
        chk(bank_open, 8'h00);
        fork
            ctrl(32'hd);
            begin
                @(posedge link.cke);
                #1;
                chk(core_on, 1'b1);
                chk(pwr_state, PWR_SR);
            end
        join
        chk(pwr_state, PWR_ACT);
    endtask
    task automatic t_odt();
        ctrl(32'hf);
        chk(term_dq, 16'hffff);
        chk(term_dm, 2'h3);
        ctrl(32'hd);
        chk(term_dq, 16'h0);
        ctrl(32'hf);
        cmd(CMD_MRS, 3'h1, 15'h0000);
        chk(term_dqs, 2'h0);
        ctrl(32'hd);
    endtask
    // refused accesses must answer with an error and change nothing
    task automatic t_refused();
        axi_wr(8'h80, 32'h1, 4'hf, r);
        chk(r, RESP_ERR);
        axi_wr(OFF_CTRL, 32'h0, 4'h1, r);
        chk(r, RESP_ERR);
        axi_rd(8'h80, d, r);
        chk(r, RESP_ERR);
        chk(d, 32'h0);
        chk(pwr_state, PWR_ACT);
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        #200000;
        bad_count++;
        report_and_stop();
    end
    initial begin
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        t_reset_state();
        t_act_bank();
        t_write_read();
        t_chop();
        t_power();
        t_precharge();
        t_selfref();
        t_odt();
        t_refused();
        report_and_stop();
    end
endmodule
